// File: dsd_pkg.sv
package dsd_pkg;
    // program store geometry, per variant
    localparam int PM_WORDS_SMALL = 2048;
    localparam int PM_WORDS_LARGE = 4096;
    localparam int IWP_W_SMALL = 11;
    localparam int IWP_W = 12;
    localparam logic [11:0] IWP_MASK_SMALL = 12'h7ff;
    localparam logic [11:0] IWP_MASK_LARGE = 12'hfff;

    // data space map, long addresses
    localparam logic [15:0] REG_TOP = 16'h001f;
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] IO_TOP = 16'h005f;
    localparam logic [15:0] IO_LONG_OFFSET = 16'h0020;
    localparam logic [15:0] EXT_TOP = 16'h00ff;
    localparam logic [15:0] SRAM_BASE = 16'h0100;
    localparam logic [15:0] SRAM_TOP_SMALL = 16'h01ff;
    localparam logic [15:0] SRAM_TOP_LARGE = 16'h02ff;
    localparam int SRAM_BYTES = 512;

    // short i/o window limits
    localparam logic [5:0] BIT_IO_TOP = 6'h1f;

    // pointer pairs, low byte register index
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;

    // scratch storage registers, short i/o addresses
    localparam logic [5:0] SCRATCH_0_ADDR = 6'h15;
    localparam logic [5:0] SCRATCH_1_ADDR = 6'h16;
    localparam logic [5:0] SCRATCH_2_ADDR = 6'h17;
    localparam logic [7:0] SCRATCH_RST = 8'h00;

    typedef enum logic [3:0] {
        OP_LONG_LOAD, OP_LONG_STORE, OP_IO_READ, OP_IO_WRITE,
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_SKIP_IF_IO_BIT_SET,
        OP_SKIP_IF_IO_BIT_CLEAR, OP_PROG_MEM_LOAD
    } dsd_op_t;

    typedef enum logic [2:0] {
        MD_DIRECT, MD_INDIRECT, MD_DISP, MD_PREDEC, MD_POSTINC
    } dsd_mode_t;

    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} dsd_ptr_t;

    typedef enum logic [2:0] {RG_REG, RG_IO, RG_EXT, RG_SRAM, RG_NONE} dsd_region_t;

    typedef struct packed {
        dsd_op_t op;
        dsd_mode_t mode;
        dsd_ptr_t ptr;
        logic [15:0] addr;
        logic [5:0] disp;
        logic [5:0] io_addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } dsd_req_t;

    typedef struct packed {
        logic ack;
        logic refused;
        logic skip;
        logic [7:0] rdata;
    } dsd_rsp_t;
endpackage : dsd_pkg

// File: dsd_addr_decoder.sv
`timescale 1ns/1ps
// Operation
// - program store is 16-bit words: 2048 small, 4096 large variant
// - instruction word pointer is 11 bits small, 12 bits large
// - long addresses 0x0000-0x001F hit the working register file
// - long 0x0020-0x005F is the i/o window, short 0x00-0x3F
// - long access to i/o uses short address plus 0x20
// - bit set/clear/test only at short i/o addresses 0x00-0x1F
// - extended i/o 0x0060-0x00FF reached only by long loads and stores
// - sram from 0x0100 to 0x01FF small or 0x02FF large
// - direct mode uses a full 16-bit address
// - displacement adds unsigned 0..63 to second or third pointer
// - pre-decrement lowers pointer first and uses the new value
// - post-increment uses pointer then raises it
// - three pointers live in working registers 26..31 as pairs
// - every mode reaches the whole volatile space
// - sram access completes in two clock cycles
// - three scratch i/o registers hold values and take bit operations
// - program-memory load reads any program store address
module dsd_addr_decoder #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_req_valid,
    input wire dsd_pkg::dsd_req_t i_req,
    input wire logic i_fetch_step,
    input wire logic i_fetch_jump,
    input wire logic [11:0] i_fetch_target,
    input wire logic [15:0] i_pm_data,
    output logic o_ready,
    output dsd_pkg::dsd_rsp_t o_rsp,
    output logic [11:0] o_instr_word_pointer,
    output logic [11:0] o_pm_addr
);
    import dsd_pkg::*;

    localparam logic [11:0] IWP_MASK = LARGE_VARIANT ? IWP_MASK_LARGE : IWP_MASK_SMALL;
    localparam logic [15:0] SRAM_TOP = LARGE_VARIANT ? SRAM_TOP_LARGE : SRAM_TOP_SMALL;

    typedef enum logic [1:0] {ST_IDLE, ST_SRAM, ST_PM} dsd_fsm_t;

    typedef struct packed {
        dsd_fsm_t fsm;
        logic ready;
        dsd_rsp_t rsp;
        logic [31:0][7:0] regs;
        logic [2:0][7:0] scratch;
        logic [11:0] iwp;
        logic [11:0] pm_addr;
        logic pm_hi;
        logic [8:0] pend_idx;
        logic pend_we;
        logic [7:0] pend_wdata;
    } dsd_state_t;

    dsd_state_t st;
    dsd_state_t next_st;
    logic [7:0] sram_mem [0:SRAM_BYTES-1];
    logic take;

    // which area of the data space a long address falls in
    function automatic dsd_region_t region_of(input logic [15:0] a);
        if (a <= REG_TOP) return RG_REG;
        if (a <= IO_TOP) return RG_IO;
        if (a <= EXT_TOP) return RG_EXT;
        if (a <= SRAM_TOP) return RG_SRAM;
        return RG_NONE;
    endfunction : region_of

    // scratch slot for a short i/o address, 3 when none
    function automatic logic [1:0] scratch_slot(input logic [5:0] io);
        unique case (io)
            SCRATCH_0_ADDR: return 2'd0;
            SCRATCH_1_ADDR: return 2'd1;
            SCRATCH_2_ADDR: return 2'd2;
            default: return 2'd3;
        endcase
    endfunction : scratch_slot

    // non-sram read; reserved and unmapped read as zero
    function automatic logic [7:0] read_loc(input dsd_state_t s, input logic [15:0] a);
        logic [5:0] io;
        logic [1:0] k;
        io = 6'(a - IO_BASE);
        k = scratch_slot(io);
        if (region_of(a) == RG_REG) return s.regs[a[4:0]];
        if (region_of(a) == RG_IO && k != 2'd3) return s.scratch[k];
        return 8'h00;
    endfunction : read_loc

    // non-sram write; reserved and unmapped are dropped
    function automatic dsd_state_t write_loc(input dsd_state_t s, input logic [15:0] a,
                                             input logic [7:0] d);
        dsd_state_t r;
        logic [5:0] io;
        logic [1:0] k;
        r = s;
        io = 6'(a - IO_BASE);
        k = scratch_slot(io);
        if (region_of(a) == RG_REG) r.regs[a[4:0]] = d;
        else if (region_of(a) == RG_IO && k != 2'd3) r.scratch[k] = d;
        return r;
    endfunction : write_loc

    // pointer pair low register from the selector
    function automatic logic [4:0] ptr_lo(input dsd_ptr_t p);
        unique case (p)
            PTR_X: return PTR_X_LO;
            PTR_Y: return PTR_Y_LO;
            default: return PTR_Z_LO;
        endcase
    endfunction : ptr_lo

    assign take = i_req_valid && st.ready;

    // one request at a time; sram and program store add a wait cycle
    always_comb begin
        logic [4:0] plo;
        logic [15:0] ptr_v;
        logic [15:0] ea;
        logic [15:0] ptr_new;
        logic ptr_upd;
        logic refuse;
        logic short_op;
        logic bit_op;
        logic [7:0] cur;
        logic [7:0] msk;
        next_st = st;
        plo = (i_req.op == OP_PROG_MEM_LOAD) ? PTR_Z_LO : ptr_lo(i_req.ptr);
        ptr_v = {st.regs[5'(plo + 5'h01)], st.regs[plo]};
        ptr_new = ptr_v;
        ptr_upd = 1'b0;
        ea = ptr_v;
        refuse = 1'b0;
        cur = 8'h00;
        msk = 8'h01 << i_req.bit_sel;
        short_op = i_req.op inside {OP_IO_READ, OP_IO_WRITE, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
                                    OP_SKIP_IF_IO_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR};
        bit_op = short_op && !(i_req.op inside {OP_IO_READ, OP_IO_WRITE});
        next_st.rsp.ack = 1'b0;
        next_st.rsp.refused = 1'b0;
        next_st.rsp.skip = 1'b0;

        // instruction word pointer walks the program store only
        if (i_fetch_jump) begin
            next_st.iwp = i_fetch_target & IWP_MASK;
        end else if (i_fetch_step) begin
            next_st.iwp = (st.iwp + 12'h001) & IWP_MASK;
        end

        unique case (st.fsm)
            ST_IDLE: begin
                if (take) begin
                    // effective address per mode
                    unique case (i_req.mode)
                        MD_DIRECT: ea = i_req.addr;
                        MD_INDIRECT: ea = ptr_v;
                        MD_DISP: ea = ptr_v + {10'h000, i_req.disp};
                        MD_PREDEC: begin
                            ea = ptr_v - 16'h0001;
                            ptr_new = ea;
                            ptr_upd = 1'b1;
                        end
                        MD_POSTINC: begin
                            ea = ptr_v;
                            ptr_new = ptr_v + 16'h0001;
                            ptr_upd = 1'b1;
                        end
                        default: ea = ptr_v;
                    endcase
                    if (short_op) begin
                        ea = {10'h000, i_req.io_addr} + IO_LONG_OFFSET;
                        ptr_upd = 1'b0;
                    end
                    // displacement only from y or z
                    if (!short_op && i_req.mode == MD_DISP && i_req.ptr == PTR_X) begin
                        refuse = 1'b1;
                    end
                    if (bit_op && i_req.io_addr > BIT_IO_TOP) refuse = 1'b1;
                    if (i_req.op == OP_PROG_MEM_LOAD) begin
                        ea = {st.regs[PTR_Z_LO + 5'h01], st.regs[PTR_Z_LO]};
                        ptr_new = ea + 16'h0001;
                        ptr_upd = (i_req.mode == MD_POSTINC);
                        refuse = !(i_req.mode inside {MD_INDIRECT, MD_POSTINC});
                    end
                    cur = read_loc(st, ea);
                    next_st.rsp.rdata = 8'h00;
                    if (refuse) begin
                        // refused: answered at once, nothing changes
                        next_st.rsp.ack = 1'b1;
                        next_st.rsp.refused = 1'b1;
                    end else begin
                        unique case (i_req.op)
                            OP_LONG_LOAD, OP_IO_READ, OP_LONG_STORE, OP_IO_WRITE: begin
                                if (region_of(ea) == RG_SRAM) begin
                                    next_st.fsm = ST_SRAM;
                                    next_st.ready = 1'b0;
                                    next_st.pend_idx = 9'(ea - SRAM_BASE);
                                    next_st.pend_we = i_req.op inside {OP_LONG_STORE,
                                                                       OP_IO_WRITE};
                                    next_st.pend_wdata = i_req.wdata;
                                end else begin
                                    next_st.rsp.ack = 1'b1;
                                    if (i_req.op inside {OP_LONG_LOAD, OP_IO_READ}) begin
                                        next_st.rsp.rdata = cur;
                                    end else begin
                                        next_st = write_loc(next_st, ea, i_req.wdata);
                                    end
                                end
                            end
                            OP_IO_BIT_SET: begin
                                next_st = write_loc(next_st, ea, cur | msk);
                                next_st.rsp.ack = 1'b1;
                            end
                            OP_IO_BIT_CLEAR: begin
                                next_st = write_loc(next_st, ea, cur & ~msk);
                                next_st.rsp.ack = 1'b1;
                            end
                            OP_SKIP_IF_IO_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR: begin
                                next_st.rsp.skip = ((cur & msk) != 8'h00) ==
                                                   (i_req.op == OP_SKIP_IF_IO_BIT_SET);
                                next_st.rsp.ack = 1'b1;
                            end
                            OP_PROG_MEM_LOAD: begin
                                next_st.pm_addr = ea[12:1] & IWP_MASK;
                                next_st.pm_hi = ea[0];
                                next_st.fsm = ST_PM;
                                next_st.ready = 1'b0;
                            end
                            default: begin
                                next_st.rsp.ack = 1'b1;
                                next_st.rsp.refused = 1'b1;
                            end
                        endcase
                        // pointer write-back lands after any register-file or scratch data write
                        if (ptr_upd) begin
                            next_st.regs[plo] = ptr_new[7:0];
                            next_st.regs[5'(plo + 5'h01)] = ptr_new[15:8];
                        end
                    end
                end
            end
            ST_SRAM: begin
                // second cycle of the sram access
                next_st.rsp.ack = 1'b1;
                next_st.rsp.rdata = st.pend_we ? 8'h00 : sram_mem[st.pend_idx];
                next_st.fsm = ST_IDLE;
                next_st.ready = 1'b1;
            end
            ST_PM: begin
                // program store word stands on i_pm_data this cycle
                next_st.rsp.ack = 1'b1;
                next_st.rsp.rdata = st.pm_hi ? i_pm_data[15:8] : i_pm_data[7:0];
                next_st.fsm = ST_IDLE;
                next_st.ready = 1'b1;
            end
            default: begin
                next_st.fsm = ST_IDLE;
                next_st.ready = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st <= '0;
            st.fsm <= ST_IDLE;
            st.ready <= 1'b1;
            st.scratch <= {3{SCRATCH_RST}};
        end else begin
            st <= next_st;
        end
    end

    // sram array; no reset, contents are undefined after power-up
    always_ff @(posedge i_core_clk) begin
        if (st.fsm == ST_SRAM && st.pend_we) begin
            sram_mem[st.pend_idx] <= st.pend_wdata;
        end
    end

    assign o_ready = st.ready;
    assign o_rsp = st.rsp;
    assign o_instr_word_pointer = st.iwp;
    assign o_pm_addr = st.pm_addr;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    logic [15:0] x_ptr;
    logic [15:0] z_ptr;
    logic refuse_any;
    assign x_ptr = {st.regs[PTR_X_LO + 5'h01], st.regs[PTR_X_LO]};
    assign z_ptr = {st.regs[PTR_Z_LO + 5'h01], st.regs[PTR_Z_LO]};
    // program load modes that the decoder turns away
    assign refuse_any = !(i_req.mode inside {MD_INDIRECT, MD_POSTINC});

    chk_sram_two_cycle: assert property (take && i_req.op == OP_LONG_LOAD &&
        i_req.mode == MD_DIRECT && i_req.addr >= SRAM_BASE && i_req.addr <= SRAM_TOP
        |=> !o_rsp.ack ##1 o_rsp.ack) else $error("sram access not two cycles");
    chk_reg_one_cycle: assert property (take && i_req.op == OP_LONG_LOAD &&
        i_req.mode == MD_DIRECT && i_req.addr <= REG_TOP
        |=> o_rsp.ack && o_rsp.rdata == $past(st.regs[i_req.addr[4:0]]))
        else $error("register file load wrong");
    chk_bit_range: assert property (take && i_req.op == OP_IO_BIT_SET &&
        i_req.io_addr > BIT_IO_TOP |=> o_rsp.ack && o_rsp.refused)
        else $error("bit op above low window accepted");
    chk_disp_x_refused: assert property (take &&
        i_req.op inside {OP_LONG_LOAD, OP_LONG_STORE} &&
        i_req.mode == MD_DISP && i_req.ptr == PTR_X |=> o_rsp.refused)
        else $error("displacement on x accepted");
    chk_predec_ptr: assert property (take && i_req.op == OP_LONG_LOAD &&
        i_req.mode == MD_PREDEC && i_req.ptr == PTR_Z |=> z_ptr == $past(z_ptr) - 16'h0001)
        else $error("pre-decrement pointer wrong");
    chk_postinc_ptr: assert property (take && i_req.op == OP_LONG_STORE &&
        i_req.mode == MD_POSTINC && i_req.ptr == PTR_X |=> x_ptr == $past(x_ptr) + 16'h0001)
        else $error("post-increment pointer wrong");
    chk_ext_reads_zero: assert property (take && i_req.op == OP_LONG_LOAD &&
        i_req.mode == MD_DIRECT && i_req.addr > IO_TOP && i_req.addr <= EXT_TOP
        |=> o_rsp.ack && o_rsp.rdata == 8'h00) else $error("extended i/o read not zero");
    chk_top_reads_zero: assert property (take && i_req.op == OP_LONG_LOAD &&
        i_req.mode == MD_DIRECT && i_req.addr > SRAM_TOP |=> o_rsp.ack && o_rsp.rdata == 8'h00)
        else $error("read above sram not zero");
    chk_iwp_width: assert property (st.iwp == (st.iwp & IWP_MASK))
        else $error("instruction pointer outside program store");
    chk_scratch_set: assert property (take && i_req.op == OP_IO_BIT_SET &&
        i_req.io_addr == SCRATCH_1_ADDR |=> st.scratch[1][$past(i_req.bit_sel)])
        else $error("scratch bit not set");
    chk_pm_answer: assert property (take && i_req.op == OP_PROG_MEM_LOAD && !refuse_any
        |=> !o_rsp.ack ##1 o_rsp.ack) else $error("program load not answered");

    cov_sram_store: cover property (take && i_req.op == OP_LONG_STORE ##2 o_rsp.ack);
    cov_skip_taken: cover property (o_rsp.ack && o_rsp.skip);
    cov_postinc_pm: cover property (take && i_req.op == OP_PROG_MEM_LOAD &&
        i_req.mode == MD_POSTINC);
endmodule : dsd_addr_decoder

// File: dsd_pm_model.sv
`timescale 1ns/1ps
// program store stand-in: each word carries its own address, so a wrong
// word address or a swapped byte shows up in the returned value
module dsd_pm_model (
    input wire logic [11:0] i_pm_addr,
    output logic [15:0] o_pm_data
);
    // every word of the store answers, no holes in the table
    assign o_pm_data = {4'h5, i_pm_addr};
endmodule : dsd_pm_model

// File: dsd_addr_decoder_tb_top.sv
`timescale 1ns/1ps
module dsd_addr_decoder_tb_top;
    import dsd_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_req_valid = 1'b0;
    dsd_req_t i_req = '0;
    logic i_fetch_step = 1'b0;
    logic i_fetch_jump = 1'b0;
    logic [11:0] i_fetch_target = 12'h000;
    logic [15:0] i_pm_data;
    logic o_ready;
    dsd_rsp_t o_rsp;
    logic [11:0] o_instr_word_pointer;
    logic [11:0] o_pm_addr;
    int err_total = 0;
    int cmp_count = 0;
    int lat_q;
    dsd_rsp_t rsp_q;

    // 250 MHz core clock
    always #2 i_core_clk = ~i_core_clk;

    dsd_addr_decoder #(.LARGE_VARIANT(1'b1)) u_dsd_addr_decoder (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_req_valid(i_req_valid),
        .i_req(i_req),
        .i_fetch_step(i_fetch_step),
        .i_fetch_jump(i_fetch_jump),
        .i_fetch_target(i_fetch_target),
        .i_pm_data(i_pm_data),
        .o_ready(o_ready),
        .o_rsp(o_rsp),
        .o_instr_word_pointer(o_instr_word_pointer),
        .o_pm_addr(o_pm_addr)
    );

    dsd_pm_model u_dsd_pm_model (
        .i_pm_addr(o_pm_addr),
        .o_pm_data(i_pm_data)
    );

    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    // one request: held until a take edge, then answer caught at mid-cycle
    task automatic go(input dsd_op_t o, input logic [15:0] a, input dsd_mode_t md,
                      input dsd_ptr_t pt, input logic [7:0] wd, input logic [5:0] io,
                      input logic [2:0] bs, input logic [5:0] dp);
        dsd_req_t r;
        int n;
        r = '0;
        r.op = o;
        r.addr = a;
        r.mode = md;
        r.ptr = pt;
        r.wdata = wd;
        r.io_addr = io;
        r.bit_sel = bs;
        r.disp = dp;
        n = 0;
        @(posedge i_core_clk);
        i_req_valid <= 1'b1;
        i_req <= r;
        // ready is looked at mid-cycle; the take is the rising edge after it
        @(negedge i_core_clk);
        while (o_ready !== 1'b1 && n < 8) begin
            @(negedge i_core_clk);
            n++;
        end
        @(posedge i_core_clk);
        i_req_valid <= 1'b0;
        lat_q = 0;
        rsp_q = '0;
        while (lat_q < 4 && rsp_q.ack !== 1'b1) begin
            @(negedge i_core_clk);
            lat_q++;
            rsp_q = o_rsp;
        end
        if (rsp_q.ack !== 1'b1) chk(16'h0000, 16'h0001, "no answer");
    endtask : go

    // plain direct store; stimulus stores only to registers, scratch and sram
    task automatic st(input logic [15:0] a, input logic [7:0] v);
        go(OP_LONG_STORE, a, MD_DIRECT, PTR_X, v, 6'h00, 3'h0, 6'h00);
    endtask : st

    // direct load, data and answer latency both judged
    task automatic ld(input logic [15:0] a, input logic [7:0] e, input int lat);
        go(OP_LONG_LOAD, a, MD_DIRECT, PTR_X, 8'h00, 6'h00, 3'h0, 6'h00);
        chk({8'h00, rsp_q.rdata}, {8'h00, e}, "load data");
        chk(16'(lat_q), 16'(lat), "load latency");
    endtask : ld

    task automatic t_reset();
        chk({15'h0, o_ready}, 16'h0001, "ready after reset");
        chk({5'h0, o_rsp}, 16'h0000, "answer after reset");
        chk({4'h0, o_instr_word_pointer}, 16'h0000, "pointer after reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_space();
        st(16'h0001, 8'h5a);
        ld(16'h0001, 8'h5a, 1);
        st(16'h0100, 8'ha1);
        chk(16'(lat_q), 16'h0002, "sram store latency");
        ld(16'h0100, 8'ha1, 2);
        st(16'h02ff, 8'hc3);
        ld(16'h02ff, 8'hc3, 2);
        ld(16'h0300, 8'h00, 1);
        go(OP_IO_WRITE, 16'h0000, MD_DIRECT, PTR_X, 8'h77, 6'h15, 3'h0, 6'h00);
        ld(16'h0035, 8'h77, 1);
        st(16'h0037, 8'h3e);
        go(OP_IO_READ, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h17, 3'h0, 6'h00);
        chk({8'h00, rsp_q.rdata}, 16'h003e, "short read of long write");
        ld(16'h0060, 8'h00, 1);
        ld(16'h005f, 8'h00, 1);
        $display("test space done");
    endtask : t_space

    task automatic t_bits();
        go(OP_IO_WRITE, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h16, 3'h0, 6'h00);
        go(OP_IO_BIT_SET, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h16, 3'h7, 6'h00);
        ld(16'h0036, 8'h80, 1);
        go(OP_SKIP_IF_IO_BIT_SET, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h16, 3'h7, 6'h00);
        chk({15'h0, rsp_q.skip}, 16'h0001, "skip on set bit");
        go(OP_IO_BIT_CLEAR, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h16, 3'h7, 6'h00);
        ld(16'h0036, 8'h00, 1);
        go(OP_SKIP_IF_IO_BIT_SET, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h16, 3'h7, 6'h00);
        chk({15'h0, rsp_q.skip}, 16'h0000, "no skip on clear bit");
        go(OP_SKIP_IF_IO_BIT_CLEAR, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h16, 3'h7, 6'h00);
        chk({15'h0, rsp_q.skip}, 16'h0001, "skip on clear bit");
        // first address above the bit-capable range must be turned away
        go(OP_IO_BIT_SET, 16'h0000, MD_DIRECT, PTR_X, 8'h00, 6'h20, 3'h0, 6'h00);
        chk({15'h0, rsp_q.refused}, 16'h0001, "bit op above range");
        $display("test bits done");
    endtask : t_bits

    task automatic t_modes();
        st(16'h001c, 8'h00);
        st(16'h001d, 8'h01);
        go(OP_LONG_STORE, 16'h0000, MD_DISP, PTR_Y, 8'h3c, 6'h00, 3'h0, 6'h3f);
        ld(16'h013f, 8'h3c, 2);
        go(OP_LONG_STORE, 16'h0000, MD_DISP, PTR_X, 8'h11, 6'h00, 3'h0, 6'h01);
        chk({15'h0, rsp_q.refused}, 16'h0001, "displacement on first pair");
        go(OP_LONG_LOAD, 16'h0000, MD_INDIRECT, PTR_Y, 8'h00, 6'h00, 3'h0, 6'h00);
        chk({8'h00, rsp_q.rdata}, 16'h00a1, "indirect sram load");
        st(16'h001a, 8'h35);
        st(16'h001b, 8'h00);
        go(OP_LONG_STORE, 16'h0000, MD_POSTINC, PTR_X, 8'h99, 6'h00, 3'h0, 6'h00);
        ld(16'h001a, 8'h36, 1);
        ld(16'h0035, 8'h99, 1);
        st(16'h001e, 8'h02);
        st(16'h001f, 8'h00);
        go(OP_LONG_LOAD, 16'h0000, MD_PREDEC, PTR_Z, 8'h00, 6'h00, 3'h0, 6'h00);
        chk({8'h00, rsp_q.rdata}, 16'h005a, "pre-decrement load");
        ld(16'h001e, 8'h01, 1);
        $display("test modes done");
    endtask : t_modes

    task automatic t_prog();
        st(16'h001e, 8'h23);
        st(16'h001f, 8'h01);
        go(OP_PROG_MEM_LOAD, 16'h0000, MD_INDIRECT, PTR_Z, 8'h00, 6'h00, 3'h0, 6'h00);
        chk({4'h0, o_pm_addr}, 16'h0091, "program word address");
        chk({8'h00, rsp_q.rdata}, 16'h0050, "odd pointer high byte");
        chk(16'(lat_q), 16'h0002, "program load latency");
        st(16'h001e, 8'hfe);
        st(16'h001f, 8'h1f);
        go(OP_PROG_MEM_LOAD, 16'h0000, MD_POSTINC, PTR_Z, 8'h00, 6'h00, 3'h0, 6'h00);
        chk({8'h00, rsp_q.rdata}, 16'h00ff, "top word low byte");
        ld(16'h001e, 8'hff, 1);
        go(OP_PROG_MEM_LOAD, 16'h0000, MD_PREDEC, PTR_Z, 8'h00, 6'h00, 3'h0, 6'h00);
        chk({15'h0, rsp_q.refused}, 16'h0001, "program load bad mode");
        $display("test prog done");
    endtask : t_prog

    task automatic t_fetch();
        @(posedge i_core_clk);
        i_fetch_jump <= 1'b1;
        i_fetch_target <= 12'hfff;
        @(posedge i_core_clk);
        i_fetch_jump <= 1'b0;
        @(negedge i_core_clk);
        chk({4'h0, o_instr_word_pointer}, 16'h0fff, "jump to top word");
        @(posedge i_core_clk);
        i_fetch_step <= 1'b1;
        @(posedge i_core_clk);
        @(posedge i_core_clk);
        i_fetch_step <= 1'b0;
        @(negedge i_core_clk);
        chk({4'h0, o_instr_word_pointer}, 16'h0001, "step wraps at store end");
        $display("test fetch done");
    endtask : t_fetch

    // close the run: counts, then verdict
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // main sequence, reset held two cycles
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(negedge i_core_clk);
        t_reset();
        t_space();
        t_bits();
        t_modes();
        t_prog();
        t_fetch();
        give_verdict();
    end

    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #40000;
        err_total++;
        give_verdict();
    end
endmodule : dsd_addr_decoder_tb_top
